//--- dcc_control.sv
// dual comparator control: mode decode, polarity, input switch, change detection, timer gate, reference control
// assumes analog cells deliver raw compare levels synchronous to pclk and the timer delivers falling-edge ticks
//
// What this block does
// - an output change at the second-phase read instant sets its flag without a flag-set pulse.
// - an enabled comparator keeps running through sleep.
// - modes 000 and 111 power both comparators down.
// - output change wakes from sleep when comparator and peripheral enables are set.
// - after wake the next instruction runs; service routine only with global enable.
// - any reset returns both configuration registers to reset, forcing mode 000.
// - result bits 7 and 6 read one when plus exceeds minus, complemented if inverted.
// - invert bits 5 and 4 complement comparator two and one outputs.
// - in mode 010 the switch bit picks plus or minus pin for both comparators.
// - in mode 001 the switch bit acts on comparator one only.
// - the mode field in bits 2 to 0 decodes the eight documented modes.
// - gate select bit 1 routes the external pin when one, comparator two when zero.
// - sync bit 0 latches comparator two on timer clock falling edges; zero passes through.
// - the sync latch uses the prescaled timer clock.
// - capture on the falling edge while the timer counts on the rising edge.
// - reference enable bit 7 powers the reference; off drives its output to ground.
// - range bit picks low or high range; a 4-bit level gives 16 steps.
// - disabled, low range and level 0000 clamps output to ground with no current.
// - unimplemented bits read zero.
// - a read latch and a first-phase latch are compared; difference sets the flag.
// - the mismatch holds the flag set until a read or the output returns.
// - a write to the configuration register also does the clearing read.
// - flags clear only on software zero; software one sets a flag.
`timescale 1ns/10ps
`include "dcc_regs.svh"
module dcc_control (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic [`DCC_ADDR_W-1:0] paddr,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic                  cmp_one_raw,
   input  wire logic                  cmp_two_raw,
   input  wire logic                  peripheral_irq_enable,
   input  wire logic                  global_irq_enable,
   input  wire logic                  timer_clk_fall,
   input  wire logic                  external_gate_pin,
   output logic                       cmp_one_power,
   output logic                       cmp_two_power,
   output logic                       pins_digital,
   output logic                       cmp_one_minus_from_plus,
   output logic                       cmp_two_minus_from_plus,
   output logic                       result_pins_enable,
   output logic                       cmp_one_result,
   output logic                       cmp_two_result,
   output logic                       timer_gate,
   output logic                       reference_enable,
   output logic                       reference_range,
   output logic      [3:0]            reference_level,
   output logic                       reference_output_grounded,
   output logic                       reference_no_current,
   output logic                       cmp_one_flag_set,
   output logic                       cmp_two_flag_set,
   output logic                       cmp_irq_flag_out,
   output logic                       wake_req,
   output logic                       irq_req
);
   import dcc_pkg::*;

   // register state
   logic [5:0]   cfg_q;         // invert bits, input switch, mode field
   logic [1:0]   tlink_q;
   logic [7:0]   ref_q;
   logic [1:0]   flag_q;        // bit0 comparator one, bit1 comparator two
   logic [1:0]   ien_q;
   logic [1:0]   phase_q;
   logic [1:0]   q1_latch_q;
   logic [1:0]   read_latch_q;
   logic [1:0]   live_res;
   logic [1:0]   mism;
   logic [1:0]   mism_prev_q;
   logic [1:0]   new_mism;
   logic [1:0]   sw_flag_d;
   logic         first_phase;
   logic         second_phase;
   logic         acc;
   logic         wr;
   logic         cfg_touch;
   logic         mapped;
   logic [7:0]   rd_byte;
   dcc_mode_type mode;
   logic         cmps_on;

   dcc_sync_if sif ();

   dcc_sync_latch u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .sif     (sif)
   );

   // four-phase divider: first and second phase enables from the core clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_q <= `DCC_PHASE_FIRST;
      end else begin
         phase_q <= phase_q + 2'h1;
      end
   end
   assign first_phase  = (phase_q == `DCC_PHASE_FIRST);
   assign second_phase = (phase_q == `DCC_PHASE_SECOND);

   // mode decode
   assign mode    = dcc_mode_type'(cfg_q[`DCC_CFG_MODE_HI:0]);
   assign cmps_on = (mode != DCC_OFF_ANALOG) && (mode != DCC_OFF_DIGITAL);

   // polarity: raw is one when plus exceeds minus; invert complements; off reads zero.
   // sleep does not gate this path, so an enabled comparator keeps detecting changes
   assign live_res[0] = cmps_on & (mode != DCC_ONE_INDEP) & (cmp_one_raw ^ cfg_q[`DCC_CFG_ONE_INV]);
   assign live_res[1] = cmps_on & (cmp_two_raw ^ cfg_q[`DCC_CFG_TWO_INV]);

   // apb decode; zero wait states, so every access phase completes in its first cycle
   assign acc       = psel & penable & pready;
   assign wr        = acc & pwrite;
   assign cfg_touch = acc & (paddr == `DCC_OFS_CONFIG);
   assign mapped    = (paddr == `DCC_OFS_CONFIG) || (paddr == `DCC_OFS_TLINK) ||
                      (paddr == `DCC_OFS_REF) || (paddr == `DCC_OFS_IRQ);

   // read mux; unimplemented bits read zero
   always_comb begin
      rd_byte = 8'h00;
      unique case (paddr)
         `DCC_OFS_CONFIG: rd_byte = {q1_latch_q[1], q1_latch_q[0], cfg_q};
         `DCC_OFS_TLINK:  rd_byte = {6'h00, tlink_q};
         `DCC_OFS_REF:    rd_byte = ref_q & `DCC_REF_WMASK;
         `DCC_OFS_IRQ:    rd_byte = {2'h0, ien_q, 2'h0, flag_q};
         default:         rd_byte = 8'h00;
      endcase
   end

   // bus answer registered in the setup cycle, shown during the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         prdata  <= (psel & ~penable & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // configuration register: result bits are read-only, rest reset to mode 000
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= 6'(`DCC_CFG_RESET);
      end else if (wr && paddr == `DCC_OFS_CONFIG) begin
         cfg_q <= pwdata[5:0];
      end
   end

   // timer link register; gate select resets to the external pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tlink_q <= `DCC_TL_RESET;
      end else if (wr && paddr == `DCC_OFS_TLINK) begin
         tlink_q <= pwdata[1:0];
      end
   end

   // reference control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_q <= `DCC_REF_RESET;
      end else if (wr && paddr == `DCC_OFS_REF) begin
         ref_q <= pwdata[7:0] & `DCC_REF_WMASK;
      end
   end

   // interrupt enables for the two comparators
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ien_q <= 2'h0;
      end else if (wr && paddr == `DCC_OFS_IRQ) begin
         ien_q <= pwdata[`DCC_IRQ_EN_LO +: 2];
      end
   end

   // first-phase latch follows the outputs every instruction cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q1_latch_q <= 2'h0;
      end else if (first_phase) begin
         q1_latch_q <= live_res;
      end
   end

   // read latch: loaded by any read of the configuration register, and by any write to it since a write opens with a read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         read_latch_q <= 2'h0;
      end else if (cfg_touch) begin
         read_latch_q <= q1_latch_q;
      end
   end

   // mismatch persists until a read realigns the latches or the output returns
   assign mism = q1_latch_q ^ read_latch_q;

   // a change landing on the second-phase read instant is absorbed by that read, so no flag-set pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mism_prev_q <= 2'h0;
      end else if (!(second_phase && cfg_touch)) begin
         mism_prev_q <= mism;
      end
   end
   assign new_mism = (second_phase && cfg_touch) ? 2'h0 : (mism & ~mism_prev_q);

   // software write: zero clears, one sets as a simulated interrupt
   always_comb begin
      sw_flag_d = flag_q;
      if (wr && paddr == `DCC_OFS_IRQ) begin
         sw_flag_d = pwdata[`DCC_IRQ_FLAG_LO +: 2];
      end
   end

   // flags: hardware set beats a software clear in the same cycle; a live mismatch keeps them set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= 2'h0;
      end else begin
         flag_q <= sw_flag_d | mism;
      end
   end

   // one pulse per comparator when a new mismatch appears
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_one_flag_set <= 1'b0;
         cmp_two_flag_set <= 1'b0;
      end else begin
         cmp_one_flag_set <= new_mism[0];
         cmp_two_flag_set <= new_mism[1];
      end
   end

   // wake ignores the global enable; the service request also needs it.
   // the core runs the instruction after sleep before vectoring, which this request leaves to it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_irq_flag_out <= 1'b0;
         wake_req         <= 1'b0;
         irq_req          <= 1'b0;
      end else begin
         cmp_irq_flag_out <= |flag_q;
         wake_req         <= |(flag_q & ien_q) & peripheral_irq_enable;
         irq_req          <= |(flag_q & ien_q) & peripheral_irq_enable & global_irq_enable;
      end
   end

   // analog cell controls from the mode decode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_one_power           <= 1'b0;
         cmp_two_power           <= 1'b0;
         pins_digital            <= 1'b0;
         cmp_one_minus_from_plus <= 1'b0;
         cmp_two_minus_from_plus <= 1'b0;
         result_pins_enable      <= 1'b0;
      end else begin
         cmp_one_power           <= cmps_on & (mode != DCC_ONE_INDEP);
         cmp_two_power           <= cmps_on;
         pins_digital            <= (mode == DCC_OFF_DIGITAL);
         cmp_one_minus_from_plus <= cfg_q[`DCC_CFG_SWITCH] &
                                    ((mode == DCC_FOUR_IN) || (mode == DCC_THREE_IN));
         cmp_two_minus_from_plus <= cfg_q[`DCC_CFG_SWITCH] & (mode == DCC_FOUR_IN);
         result_pins_enable      <= (mode == DCC_COMMON_OUT);
      end
   end

   // registered comparator results for pins and internal users
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_one_result <= 1'b0;
         cmp_two_result <= 1'b0;
      end else begin
         cmp_one_result <= live_res[0];
         cmp_two_result <= live_res[1];
      end
   end

   // comparator-two path toward the timer gate
   assign sif.cmp_level = live_res[1];
   assign sif.sync_on   = tlink_q[`DCC_TL_SYNC];
   assign sif.fall_tick = timer_clk_fall;

   // gate source: external pin when select is one, comparator two otherwise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_gate <= 1'b0;
      end else begin
         timer_gate <= tlink_q[`DCC_TL_GATE_SEL] ? external_gate_pin : sif.cmp_synced;
      end
   end

   // reference controls; disabled grounds the output, clamp state draws no current
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reference_enable          <= 1'b0;
         reference_range           <= 1'b0;
         reference_level           <= 4'h0;
         reference_output_grounded <= 1'b1;
         reference_no_current      <= 1'b0;
      end else begin
         reference_enable          <= ref_q[`DCC_REF_EN];
         reference_range           <= ref_q[`DCC_REF_RANGE];
         reference_level           <= ref_q[`DCC_REF_LVL_HI:0];
         reference_output_grounded <= ~ref_q[`DCC_REF_EN];
         reference_no_current      <= ~ref_q[`DCC_REF_EN] & ref_q[`DCC_REF_RANGE] &
                                      (ref_q[`DCC_REF_LVL_HI:0] == 4'h0);
      end
   end

endmodule

//--- dcc_regs.svh
// register offsets, field positions, reset values and timing figures of the dual comparator control
// assumes an apb slave with 32-bit data, one aligned word per register
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH

`define DCC_ADDR_W        12
`define DCC_OFS_CONFIG    12'h000
`define DCC_OFS_TLINK     12'h004
`define DCC_OFS_REF       12'h008
`define DCC_OFS_IRQ       12'h00c

// comparator_config fields
`define DCC_CFG_TWO_RES   7
`define DCC_CFG_ONE_RES   6
`define DCC_CFG_TWO_INV   5
`define DCC_CFG_ONE_INV   4
`define DCC_CFG_SWITCH    3
`define DCC_CFG_MODE_HI   2
`define DCC_CFG_RESET     8'h00

// comparator_timer_link fields
`define DCC_TL_GATE_SEL   1
`define DCC_TL_SYNC       0
`define DCC_TL_RESET      2'h2

// reference_control fields
`define DCC_REF_EN        7
`define DCC_REF_RANGE     5
`define DCC_REF_LVL_HI    3
`define DCC_REF_RESET     8'h00
`define DCC_REF_WMASK     8'haf

// comparator irq register fields: flags in 1:0, enables in 5:4
`define DCC_IRQ_FLAG_LO   0
`define DCC_IRQ_EN_LO     4

// core clock phases: four system clocks per instruction cycle
`define DCC_PHASES        4
`define DCC_PHASE_FIRST   2'h0
`define DCC_PHASE_SECOND  2'h1

`endif

//--- dcc_pkg.sv
// types shared by the dual comparator control modules
// assumes dcc_regs.svh holds the register numeric constants; the mode codes are defined here
package dcc_pkg;

   // mode codes follow the 3-bit mode field; gray order is not meaningful for a decode
   typedef enum logic [2:0] {
      DCC_OFF_ANALOG  = 3'h0,
      DCC_THREE_IN    = 3'h1,
      DCC_FOUR_IN     = 3'h2,
      DCC_COMMON_REF  = 3'h3,
      DCC_TWO_INDEP   = 3'h4,
      DCC_ONE_INDEP   = 3'h5,
      DCC_COMMON_OUT  = 3'h6,
      DCC_OFF_DIGITAL = 3'h7
   } dcc_mode_type;

endpackage

//--- dcc_sync_if.sv
// carrier between the control top and the comparator-two sync latch
// assumes one clock; the timer falling-edge tick is an enable pulse on it
`timescale 1ns/10ps
interface dcc_sync_if;
   logic cmp_level;
   logic sync_on;
   logic fall_tick;
   logic cmp_synced;

   modport ctrl (output cmp_level, output sync_on, output fall_tick, input cmp_synced);
   modport latch (input cmp_level, input sync_on, input fall_tick, output cmp_synced);
endinterface

//--- dcc_sync_latch.sv
// comparator-two output latch, loaded on the falling edge of the (prescaled) timer clock
// assumes the timer supplies that falling edge as a one-cycle tick synchronous to pclk
`timescale 1ns/10ps
module dcc_sync_latch (
   input  wire logic   pclk,
   input  wire logic   presetn,
   dcc_sync_if.latch   sif
);
   import dcc_pkg::*;

   logic held_q;

   // capture on the falling tick only, so the timer's rising-edge count never races the gate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         held_q <= 1'b0;
      end else if (sif.fall_tick) begin
         held_q <= sif.cmp_level;
      end
   end

   // sync off passes the live level straight through
   assign sif.cmp_synced = sif.sync_on ? held_q : sif.cmp_level;
endmodule

//--- dcc_control_monitor.sv
// concurrent checks on the dual comparator control ports
// assumes one pclk domain with presetn as asynchronous active-low reset
`timescale 1ns/10ps
module dcc_control_monitor (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic       peripheral_irq_enable,
   input wire logic       cmp_one_power,
   input wire logic       cmp_two_power,
   input wire logic       pins_digital,
   input wire logic       result_pins_enable,
   input wire logic       cmp_one_minus_from_plus,
   input wire logic       cmp_two_minus_from_plus,
   input wire logic       cmp_two_result,
   input wire logic       reference_enable,
   input wire logic       reference_range,
   input wire logic [3:0] reference_level,
   input wire logic       reference_output_grounded,
   input wire logic       reference_no_current,
   input wire logic       cmp_one_flag_set,
   input wire logic       cmp_two_flag_set,
   input wire logic       cmp_irq_flag_out,
   input wire logic       wake_req,
   input wire logic       irq_req
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // no wait states: every setup cycle is answered in the next cycle
   a_apb_answer: assert property (psel && !penable |=> pready) else $error("apb answer missing");
   a_err_ready: assert property (pslverr |-> pready) else $error("slave error without ready");
   a_ref_ground: assert property (reference_output_grounded == !reference_enable)
      else $error("reference ground does not follow enable");
   a_ref_no_current: assert property (
      reference_no_current == (!reference_enable && reference_range && reference_level == 4'h0))
      else $error("reference clamp condition wrong");
   a_off_digital: assert property (pins_digital |-> !cmp_one_power && !cmp_two_power)
      else $error("comparator powered in off mode");
   a_off_result: assert property (!cmp_two_power |-> !cmp_two_result)
      else $error("result from powered down comparator");
   a_common_out: assert property (result_pins_enable |-> cmp_one_power && cmp_two_power)
      else $error("output mode without both comparators");
   a_switch_pair: assert property (cmp_two_minus_from_plus |-> cmp_one_minus_from_plus)
      else $error("switch moved comparator two alone");
   a_flag_pulse: assert property (cmp_one_flag_set |=> !cmp_one_flag_set)
      else $error("flag set pulse longer than one cycle");
   a_flag_level: assert property (cmp_two_flag_set |-> ##[0:1] cmp_irq_flag_out)
      else $error("flag pulse without flag level");
   a_wake_enable: assert property (wake_req |-> $past(peripheral_irq_enable))
      else $error("wake without peripheral enable");
   a_irq_from_wake: assert property (irq_req |-> wake_req || $past(wake_req))
      else $error("interrupt without wake request");

   c_flag: cover property (cmp_one_flag_set);
   c_wake: cover property (wake_req && !irq_req);
   c_irq: cover property (irq_req);
   c_err: cover property (pslverr);
endmodule

bind dcc_control dcc_control_monitor mon (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
   .peripheral_irq_enable, .cmp_one_power, .cmp_two_power, .pins_digital, .result_pins_enable,
   .cmp_one_minus_from_plus, .cmp_two_minus_from_plus, .cmp_two_result, .reference_enable,
   .reference_range, .reference_level, .reference_output_grounded, .reference_no_current,
   .cmp_one_flag_set, .cmp_two_flag_set, .cmp_irq_flag_out, .wake_req, .irq_req);

//--- dcc_analog_model.sv
// comparator cells and prescaled timer clock seen from the control block
// assumes the bench applies compare levels and starts the timer with run
`timescale 1ns/10ps
module dcc_analog_model #(
   parameter int PRESC = 3
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic run,
   input  wire logic lvl_one,
   input  wire logic lvl_two,
   output logic      cmp_one_raw,
   output logic      cmp_two_raw,
   output logic      timer_clk_fall
);
   int div_q;

   // cells settle one clock after the levels move
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_one_raw <= 1'b0;
         cmp_two_raw <= 1'b0;
      end else begin
         cmp_one_raw <= lvl_one;
         cmp_two_raw <= lvl_two;
      end
   end

   // falling edge after the prescaler only; the timer counts on the other edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q          <= 0;
         timer_clk_fall <= 1'b0;
      end else begin
         div_q          <= (run && div_q < PRESC - 1) ? div_q + 1 : 0;
         timer_clk_fall <= run && div_q == PRESC - 1;
      end
   end
endmodule

//--- dcc_control_tb.sv
// self-checking bench for the dual comparator control
// assumes dcc_control as apb slave and dcc_analog_model as cells and timer
`timescale 1ns/10ps
`include "dcc_regs.svh"
module dcc_control_tb;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        peripheral_irq_enable = 1'b0, global_irq_enable = 1'b0, external_gate_pin = 1'b0;
   logic        run = 1'b0, lvl_one = 1'b0, lvl_two = 1'b0, er;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, cmp_one_raw, cmp_two_raw, timer_clk_fall, timer_gate;
   logic        cmp_one_power, cmp_two_power, pins_digital, result_pins_enable, irq_req;
   logic        cmp_one_minus_from_plus, cmp_two_minus_from_plus, cmp_one_result, cmp_two_result;
   logic        reference_enable, reference_range, reference_output_grounded, reference_no_current;
   logic [3:0]  reference_level;
   logic        cmp_one_flag_set, cmp_two_flag_set, cmp_irq_flag_out, wake_req;
   int          n_mismatch = 0, compares = 0;
   // write value in 15:8; power one/two, digital, output pins, switch one/two in 5:0
   logic [15:0] rows [8] = '{16'h0800, 16'h0932, 16'h0a33, 16'h0b30, 16'h0c30, 16'h0d10, 16'h0e34, 16'h0f08};
   // write value in 15:8; enable, range, level, grounded, no current in 7:0
   logic [15:0] refs [3] = '{16'hfffc, 16'h2043, 16'h0a2a};
   wire  [5:0]  mode_outs = {cmp_one_power, cmp_two_power, pins_digital, result_pins_enable,
                             cmp_one_minus_from_plus, cmp_two_minus_from_plus};
   wire  [7:0]  ref_outs = {reference_enable, reference_range, reference_level,
                            reference_output_grounded, reference_no_current};

   dcc_control DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .cmp_one_raw, .cmp_two_raw, .peripheral_irq_enable, .global_irq_enable, .timer_clk_fall,
      .external_gate_pin, .cmp_one_power, .cmp_two_power, .pins_digital, .cmp_one_minus_from_plus,
      .cmp_two_minus_from_plus, .result_pins_enable, .cmp_one_result, .cmp_two_result, .timer_gate,
      .reference_enable, .reference_range, .reference_level, .reference_output_grounded,
      .reference_no_current, .cmp_one_flag_set, .cmp_two_flag_set, .cmp_irq_flag_out, .wake_req, .irq_req);

   dcc_analog_model #(.PRESC(3)) cells (.pclk, .presetn, .run, .lvl_one, .lvl_two, .cmp_one_raw,
      .cmp_two_raw, .timer_clk_fall);

   always #25 pclk = ~pclk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, msg, got, exp);
      end
   endtask

   task automatic wrap_up();
      $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic hang(input string msg);
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s timed out", $time, msg);
      wrap_up();
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) hang("apb");
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string msg);
      apb(a, 1'b0, 8'h00);
      chk(rd, exp, msg);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // flag pulses and timer ticks last one cycle, so every edge is looked at
   task automatic wait_sig(input int s);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while ((s == 0 ? cmp_one_flag_set : s == 1 ? cmp_two_flag_set : timer_clk_fall) !== 1'b1 && n < 40);
      if (n >= 40) hang("wait");
   endtask

   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         apb(`DCC_OFS_CONFIG, 1'b1, rows[i][15:8]);
         idle(3);
         chk({26'h0, mode_outs}, {26'h0, rows[i][5:0]}, "mode decode");
         rdchk(`DCC_OFS_CONFIG, {24'h0, rows[i][15:8]}, "config readback");
      end
      for (int i = 0; i < 3; i++) begin
         apb(`DCC_OFS_REF, 1'b1, refs[i][15:8]);
         idle(3);
         chk({24'h0, ref_outs}, {24'h0, refs[i][7:0]}, "reference outputs");
         rdchk(`DCC_OFS_REF, {24'h0, refs[i][15:8] & 8'haf}, "reference readback");
      end
      $display("test done: mode and reference tables");
      // change detection: settle, clear mismatch and flags, then enable
      apb(`DCC_OFS_CONFIG, 1'b1, 8'h04);
      peripheral_irq_enable <= 1'b1;
      idle(6);
      apb(`DCC_OFS_CONFIG, 1'b0, 8'h00);
      apb(`DCC_OFS_IRQ, 1'b1, 8'h30);
      lvl_one <= 1'b1;
      wait_sig(0);
      idle(3);
      chk({29'h0, cmp_irq_flag_out, wake_req, irq_req}, 32'h6, "wake without global enable");
      global_irq_enable <= 1'b1;
      idle(2);
      chk({31'h0, irq_req}, 32'h1, "irq with global enable");
      apb(`DCC_OFS_IRQ, 1'b1, 8'h30);
      rdchk(`DCC_OFS_IRQ, 32'h31, "flag held by mismatch");
      rdchk(`DCC_OFS_CONFIG, 32'h44, "result after change");
      apb(`DCC_OFS_IRQ, 1'b1, 8'h30);
      rdchk(`DCC_OFS_IRQ, 32'h30, "flag cleared after read");
      global_irq_enable <= 1'b0;
      apb(`DCC_OFS_IRQ, 1'b1, 8'h32);
      rdchk(`DCC_OFS_IRQ, 32'h32, "software set");
      $display("test done: change detection");
      apb(`DCC_OFS_CONFIG, 1'b1, 8'h14);
      idle(6);
      chk({31'h0, cmp_one_result}, 32'h0, "inverted result");
      rdchk(`DCC_OFS_CONFIG, 32'h14, "inverted readback");
      lvl_two <= 1'b1;
      wait_sig(1);
      apb(`DCC_OFS_CONFIG, 1'b1, 8'h14);
      apb(`DCC_OFS_IRQ, 1'b1, 8'h30);
      rdchk(`DCC_OFS_IRQ, 32'h30, "write ends mismatch");
      rdchk(`DCC_OFS_CONFIG, 32'h94, "both results");
      $display("test done: inversion and write clear");
      // gate from the pin first, then from comparator two with sync on, then with sync off
      apb(`DCC_OFS_TLINK, 1'b1, 8'hff);
      rdchk(`DCC_OFS_TLINK, 32'h3, "link readback");
      external_gate_pin <= 1'b1;
      idle(3);
      chk({31'h0, timer_gate}, 32'h1, "gate from pin");
      run <= 1'b1;
      wait_sig(2);
      run <= 1'b0;
      apb(`DCC_OFS_TLINK, 1'b1, 8'h01);
      external_gate_pin <= 1'b0;
      lvl_two <= 1'b0;
      idle(6);
      chk({31'h0, timer_gate}, 32'h1, "synced gate holds");
      run <= 1'b1;
      wait_sig(2);
      idle(3);
      chk({31'h0, timer_gate}, 32'h0, "synced gate on tick");
      run <= 1'b0;
      apb(`DCC_OFS_TLINK, 1'b1, 8'h00);
      lvl_two <= 1'b1;
      idle(4);
      chk({30'h0, cmp_two_result, timer_gate}, 32'h3, "gate passes through");
      $display("test done: timer gate");
      presetn <= 1'b0;
      idle(2);
      presetn <= 1'b1;
      rdchk(`DCC_OFS_CONFIG, 32'h0, "config after reset");
      rdchk(`DCC_OFS_TLINK, 32'h2, "link after reset");
      rdchk(`DCC_OFS_REF, 32'h0, "reference after reset");
      rdchk(12'h010, 32'h0, "unmapped read data");
      chk({31'h0, er}, 32'h1, "unmapped error");
      $display("test done: reset and unmapped");
      wrap_up();
   end
endmodule
